// ---- pkg/sonar_pkg.sv ----
package sonar_pkg;
  // Clock rate and derived counts
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CLK_NS          = 10;
  // Transmit burst: 16 pulses at 49.4 kHz (half period in cycles)
  localparam int unsigned BURST_HZ_X10    = 494_000;
  localparam int unsigned BURST_PULSES    = 16;
  localparam int unsigned HALF_PERIOD_CYC = (CLK_HZ * 10) / (2 * BURST_HZ_X10);
  // Blanking 2.38 ms, in microseconds
  localparam int unsigned BLANK_US        = 2380;
  localparam int unsigned BLANK_CYC       = BLANK_US * 100;
  // Gain reaches maximum at 38 ms
  localparam int unsigned GAIN_MAX_MS     = 38;
  localparam int unsigned GAIN_MAX_CYC    = GAIN_MAX_MS * 100_000;
  localparam int unsigned GAIN_STEPS      = 8;
  localparam int unsigned GAIN_W          = 3;
  // Host timing: power-up wait 5 ms, clear pulse 0.44 ms, 0.9 ms per foot
  localparam int unsigned POWERUP_MS      = 5;
  localparam int unsigned POWERUP_CYC     = POWERUP_MS * 100_000;
  localparam int unsigned CLEAR_US        = 440;
  localparam int unsigned CLEAR_CYC       = CLEAR_US * 100;
  localparam int unsigned US_PER_FOOT     = 900;
  localparam int unsigned CYC_PER_FOOT    = US_PER_FOOT * 100;
  localparam int unsigned CNT_W           = 32;
endpackage

// ---- pkg/sonar_if.sv ----
`timescale 1ns/1ps
interface sonar_if;
  logic trigger;               // Measurement trigger, host to device
  logic echo_clear_in;         // Re-arm detection, host to device
  logic blanking_override_in;  // End blanking early, host to device
  logic echo;                  // Return-detect, device to host
  modport device (input trigger, input echo_clear_in, input blanking_override_in, output echo);
  modport host   (output trigger, output echo_clear_in, output blanking_override_in, input echo);
endinterface

// ---- rtl/sonar_device.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// R1: Echo output high when return detected
// R2: Echo delay from trigger tracks distance
// R3: Host converts delay at 0.9 ms/foot; sonar_host reports cycles only
// R4: Host lowers trigger before next rise
// R5: Clear pulse re-arms echo output
// R6: Host holds clear at least 0.44 ms
// R7: Gain rises in discrete timed steps
// R8: Maximum gain at 38 ms, then held
// R9: Sixteen 49.4 kHz pulses then bias
// R10: Receive ignored 2.38 ms after trigger
// R11: Override ends blanking immediately
// R12: Host waits 5 ms after power-up
// R13: Trigger low clears echo, restarts gain
module sonar_device #(
  parameter int unsigned BLANK_CYCLES = sonar_pkg::BLANK_CYC,
  parameter int unsigned GAIN_CYCLES  = sonar_pkg::GAIN_MAX_CYC
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  sonar_if.device                         link,
  input  wire logic                       receive_input_i,
  output logic                            transducer_drive_o,
  output logic [sonar_pkg::GAIN_W-1:0]    gain_o
);
  import sonar_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_BURST  = 2'b01,
    ST_LISTEN = 2'b10
  } dev_state_t;

  localparam int unsigned STEP_CYC = GAIN_CYCLES / (GAIN_STEPS - 1); // Cycles per gain step

  // Phase and burst group
  dev_state_t        state, next_state;     // Cycle phase
  logic              trig_d, next_trig_d;   // Trigger delayed, for edge
  logic [CNT_W-1:0]  half, next_half;       // Half-period counter
  logic [4:0]        edges, next_edges;     // Burst half-cycles done
  logic              drive, next_drive;     // Transducer level
  // Timing group
  logic [CNT_W-1:0]  tcount, next_tcount;   // Cycles since trigger rise
  logic              blank, next_blank;     // Receive blanking active
  logic [GAIN_W-1:0] gain, next_gain;       // Gain setting
  // Detection group
  logic              echo, next_echo;       // Echo output level
  logic              armed, next_armed;     // Detection armed
  // Shared by all groups
  logic              start_seen;            // Fresh trigger rise while idle

  // Count at which gain leaves a level; seven steps so that
  // the top level lands on GAIN_CYCLES, not one step short
  function automatic logic [CNT_W-1:0] step_end(input logic [GAIN_W-1:0] level);
    return CNT_W'(STEP_CYC) * (CNT_W'(level) + CNT_W'(1)) - CNT_W'(1);
  endfunction

  // A rise counts only after trigger was seen low; trig_d resets high
  // so a trigger already high at reset release cannot start a cycle
  assign start_seen = (state == ST_IDLE) && link.trigger && !trig_d;

  // Phase and burst: next values
  always_comb begin
    next_state  = state;
    next_trig_d = link.trigger;
    next_half   = half;
    next_edges  = edges;
    next_drive  = drive;
    if (!link.trigger) begin
      // Trigger low aborts; transducer back to bias
      next_state = ST_IDLE;  // [R13]
      next_drive = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          // Rising edge starts the burst on a high half-period
          if (start_seen) begin
            next_state = ST_BURST;  // [R9]
            next_drive = 1'b1;
            next_half  = '0;
            next_edges = '0;
          end
        end
        ST_BURST: begin
          // Toggle each half period, 32 half-cycles make 16 pulses
          if (half == CNT_W'(HALF_PERIOD_CYC - 1)) begin
            next_half = '0;
            if (edges == 5'(2 * BURST_PULSES - 1)) begin
              // Last half-period done; rest at receive bias
              next_state = ST_LISTEN;  // [R9]
              next_drive = 1'b0;
            end else begin
              // Next half-period, opposite level
              next_edges = edges + 5'd1;
              next_drive = ~drive;     // [R9]
            end
          end else begin
            // Still inside the half-period
            next_half = half + CNT_W'(1);
          end
        end
        ST_LISTEN: begin
          // Burst over; drive stays at bias until trigger falls
          next_drive = 1'b0;
        end
        default: begin
          // Unused code; fall back to idle at bias
          next_state = ST_IDLE;
          next_drive = 1'b0;
        end
      endcase
    end
  end

  // Phase and burst: registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= ST_IDLE;
      trig_d <= 1'b1;   // Forces a fresh low before first cycle
      half   <= '0;
      edges  <= '0;
      drive  <= 1'b0;
    end else begin
      state  <= next_state;
      trig_d <= next_trig_d;
      half   <= next_half;
      edges  <= next_edges;
      drive  <= next_drive;
    end
  end

  // Timing: age of the cycle, blanking and gain steps
  always_comb begin
    next_tcount = tcount;
    next_blank  = blank;
    next_gain   = gain;
    if (!link.trigger) begin
      // Trigger low restarts the gain ramp from the bottom
      next_tcount = '0;
      next_blank  = 1'b1;
      next_gain   = '0;  // [R13]
    end else if (start_seen) begin
      // New cycle: count from zero, receiver blanked
      next_tcount = '0;
      next_blank  = 1'b1;  // [R10]
    end else if (state != ST_IDLE) begin
      // Saturates so a very long wait cannot wrap and restep gain
      if (tcount != '1) begin
        next_tcount = tcount + CNT_W'(1);
      end
      // Blanking expires on time or on host override
      if (tcount >= CNT_W'(BLANK_CYCLES - 1) || link.blanking_override_in) begin
        next_blank = 1'b0;  // [R10] [R11]
      end
      // One step at each fixed time, then held at the top
      if (gain != GAIN_W'(GAIN_STEPS - 1) && tcount == step_end(gain)) begin
        next_gain = gain + GAIN_W'(1);  // [R7] [R8]
      end
    end
  end

  // Timing: registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tcount <= '0;
      blank  <= 1'b1;
      gain   <= '0;
    end else begin
      tcount <= next_tcount;
      blank  <= next_blank;
      gain   <= next_gain;
    end
  end

  // Detection: echo flag and re-arm after a clear pulse
  always_comb begin
    next_echo  = echo;
    next_armed = armed;
    if (!link.trigger) begin
      // Trigger low drops the echo, ready for the next cycle
      next_echo  = 1'b0;  // [R13]
      next_armed = 1'b0;
    end else if (start_seen) begin
      // Fresh cycle starts armed
      next_armed = 1'b1;
    end else if (state != ST_IDLE) begin
      // Clear wins over a return in the same cycle; the cycle
      // after its release is still refused while re-arming
      if (link.echo_clear_in) begin
        next_echo  = 1'b0;  // [R5]
        next_armed = 1'b0;
      end else if (!armed) begin
        next_armed = 1'b1;  // [R5]
      end
      // Detection only after burst, outside blanking, while armed
      if (state == ST_LISTEN && !blank && armed && !link.echo_clear_in && receive_input_i) begin
        next_echo = 1'b1;  // [R1] [R2]
      end
    end
  end

  // Detection: registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      echo  <= 1'b0;
      armed <= 1'b0;
    end else begin
      echo  <= next_echo;
      armed <= next_armed;
    end
  end

  // Outputs straight from their flops
  assign link.echo          = echo;
  assign transducer_drive_o = drive;
  assign gain_o             = gain;
endmodule

// ---- rtl/sonar_host.sv ----
`timescale 1ns/1ps
module sonar_host #(
  parameter int unsigned POWERUP_CYCLES = sonar_pkg::POWERUP_CYC,
  parameter int unsigned CLEAR_CYCLES   = sonar_pkg::CLEAR_CYC
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  sonar_if.host                            link,
  input  wire logic                        start_i,
  input  wire logic                        multi_echo_i,
  input  wire logic                        override_i,
  output logic                             ready_o,
  output logic                             result_valid_o,
  output logic [sonar_pkg::CNT_W-1:0]      echo_cycles_o
);
  import sonar_pkg::*;

  typedef enum logic [2:0] {
    HS_POWERUP = 3'b000,
    HS_IDLE    = 3'b001,
    HS_WAIT    = 3'b010,
    HS_CLEAR   = 3'b011,
    HS_LOW     = 3'b100
  } host_state_t;

  host_state_t      state, next_state;   // Host phase
  logic [CNT_W-1:0] cnt, next_cnt;       // Wait counter
  logic [CNT_W-1:0] tof, next_tof;       // Cycles since trigger
  logic             trig, next_trig;     // Trigger pin
  logic             clr, next_clr;       // Clear pin
  logic             ovr, next_ovr;       // Override pin
  logic             rdy, next_rdy;       // Ready for a start
  logic             vld, next_vld;       // Result pulse
  logic [CNT_W-1:0] res, next_res;       // Measured delay

  // Next-state logic; range is res / CYC_PER_FOOT feet, left to user [R3]
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_tof   = (tof != '1) ? tof + CNT_W'(1) : tof;
    next_trig  = trig;
    next_clr   = clr;
    next_ovr   = override_i & trig;  // [R11]
    next_rdy   = 1'b0;
    next_vld   = 1'b0;
    next_res   = res;
    case (state)
      HS_POWERUP: begin
        // Power-up wait before first trigger
        next_cnt = cnt + CNT_W'(1);
        if (cnt >= CNT_W'(POWERUP_CYCLES - 1)) next_state = HS_IDLE;  // [R12]
      end
      HS_IDLE: begin
        next_rdy = 1'b1;
        if (start_i) begin
          next_trig  = 1'b1;  // Trigger was low since last cycle [R4]
          next_tof   = '0;
          next_rdy   = 1'b0;
          next_state = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (link.echo) begin
          next_res = tof;  // Delay from trigger rise [R2]
          next_vld = 1'b1;
          if (multi_echo_i) begin
            next_clr   = 1'b1;  // [R5]
            next_cnt   = '0;
            next_state = HS_CLEAR;
          end else begin
            next_trig  = 1'b0;  // [R4]
            next_state = HS_LOW;
          end
        end else if (!start_i) begin
          // User abandons the cycle
          next_trig  = 1'b0;
          next_state = HS_LOW;
        end
      end
      HS_CLEAR: begin
        // Hold clear for its minimum width
        next_cnt = cnt + CNT_W'(1);
        if (cnt >= CNT_W'(CLEAR_CYCLES - 1)) begin
          next_clr   = 1'b0;  // [R6]
          next_state = HS_WAIT;
        end
      end
      HS_LOW: begin
        // One low cycle at least before the next rise
        next_state = HS_IDLE;  // [R4]
      end
      default: next_state = HS_POWERUP;
    endcase
  end

  // Register all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= HS_POWERUP;
      cnt   <= '0;
      tof   <= '0;
      trig  <= 1'b0;
      clr   <= 1'b0;
      ovr   <= 1'b0;
      rdy   <= 1'b0;
      vld   <= 1'b0;
      res   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      tof   <= next_tof;
      trig  <= next_trig;
      clr   <= next_clr;
      ovr   <= next_ovr;
      rdy   <= next_rdy;
      vld   <= next_vld;
      res   <= next_res;
    end
  end

  assign link.trigger              = trig;
  assign link.echo_clear_in        = clr;
  assign link.blanking_override_in = ovr;
  assign ready_o                   = rdy;
  assign result_valid_o            = vld;
  assign echo_cycles_o             = res;
endmodule

// ---- tb/sonar_asserts.sv ----
`timescale 1ns/1ps
module sonar_asserts #(
  parameter int unsigned BLANK_CYCLES = sonar_pkg::BLANK_CYC
) (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      trigger,
  input wire logic                      echo_clear_in,
  input wire logic                      blanking_override_in,
  input wire logic                      echo,
  input wire logic                      receive_input_i,
  input wire logic                      transducer_drive_o,
  input wire logic [sonar_pkg::GAIN_W-1:0] gain_o
);
  import sonar_pkg::*;
  localparam int GMAX = 810;  // Gain count of 800 plus slack
  int unsigned since;         // Cycles since trigger rose
  int unsigned next_since;
  // Age of the cycle, zero while trigger is low
  always_comb next_since = trigger ? since + 1 : 0;
  always_ff @(posedge clk_i) since <= rst_i ? 0 : next_since;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  echo_cause_a: assert property ($rose(echo) |-> $past(receive_input_i) && trigger)
    else $error("echo rose without return");
  blank_hold_a: assert property ($rose(echo) |-> blanking_override_in || since >= BLANK_CYCLES - 2)
    else $error("echo inside blanking");
  clear_echo_a: assert property (echo_clear_in |=> !echo)
    else $error("clear did not drop echo");
  trig_low_a: assert property (!trigger |=> !echo && gain_o == 0 && !transducer_drive_o)
    else $error("trigger low left state");
  burst_start_a: assert property ($rose(trigger) |=> transducer_drive_o[*8])
    else $error("burst did not start");
  gain_step_a: assert property (trigger && $past(trigger) && $changed(gain_o) |-> gain_o == $past(gain_o) + 1)
    else $error("gain jumped");
  gain_max_a: assert property ($rose(trigger) |-> ##[1:GMAX] gain_o == 3'h7)
    else $error("gain max late");
  gain_hold_a: assert property (gain_o == 3'h7 && trigger |=> gain_o == 3'h7)
    else $error("gain max not held");
endmodule

// ---- tb/sonar_echo_timing_control_test.sv ----
`timescale 1ns/1ps
module sonar_echo_timing_control_test;
  import sonar_pkg::*;
  localparam int BLANK = 34000;  // Past the burst, so override matters
  logic clk_i = 0, rst_i = 1, start_i = 0, multi_echo_i = 0, override_i = 0, receive_input_i = 0;
  logic              ready_o, result_valid_o, transducer_drive_o;
  logic [CNT_W-1:0]  echo_cycles_o;
  logic [GAIN_W-1:0] gain_o;
  int fail_count = 0, checks_done = 0;
  int cyc = 0, t_trg, t_echo, t_rx, t_clr, clr_len, pulses;  // Monitor stamps
  logic trg_q = 0, echo_q = 0, drv_q = 0, clr_q = 0;
  always #5 clk_i = ~clk_i;
  sonar_if lnk();
  sonar_device #(.BLANK_CYCLES(BLANK), .GAIN_CYCLES(800)) i_sonar_device (.clk_i(clk_i), .rst_i(rst_i),
    .link(lnk.device), .receive_input_i(receive_input_i), .transducer_drive_o(transducer_drive_o), .gain_o(gain_o));
  sonar_host #(.POWERUP_CYCLES(20), .CLEAR_CYCLES(10)) i_sonar_host (.clk_i(clk_i), .rst_i(rst_i), .link(lnk.host),
    .start_i(start_i), .multi_echo_i(multi_echo_i), .override_i(override_i), .ready_o(ready_o),
    .result_valid_o(result_valid_o), .echo_cycles_o(echo_cycles_o));
  sonar_asserts #(.BLANK_CYCLES(BLANK)) i_sonar_asserts (.clk_i(clk_i), .rst_i(rst_i), .trigger(lnk.trigger),
    .echo_clear_in(lnk.echo_clear_in), .blanking_override_in(lnk.blanking_override_in), .echo(lnk.echo),
    .receive_input_i(receive_input_i), .transducer_drive_o(transducer_drive_o), .gain_o(gain_o));
  // Edge stamps, taken after the edge settles to avoid races
  always @(posedge clk_i) begin
    #2;
    cyc++;
    if (lnk.trigger && !trg_q) t_trg = cyc;
    if (lnk.trigger && !trg_q) pulses = 0;
    if (transducer_drive_o && !drv_q) pulses++;
    if (lnk.echo && !echo_q) t_echo = cyc;
    if (lnk.echo_clear_in && !clr_q) t_clr = cyc;
    if (!lnk.echo_clear_in && clr_q) clr_len = cyc - t_clr;
    trg_q = lnk.trigger;
    echo_q = lnk.echo;
    drv_q = transducer_drive_o;
    clr_q = lnk.echo_clear_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Signal picker, so one bounded wait serves all
  function automatic logic sig(int k);
    case (k)
      0: return ready_o;
      1: return result_valid_o;
      2: return lnk.echo;
      3: return lnk.echo_clear_in;
      default: return lnk.trigger;
    endcase
  endfunction
  // Bounded wait; running out counts a mismatch and ends the run
  task automatic await(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(k) !== v) begin
      @(negedge clk_i);
      n++;
      if (n > lim) begin
        fail_count++;
        summarize();
      end
    end
  endtask
  // Single echo, override ends blanking early
  task automatic single_override();
    int d;
    await(0, 1, 100);
    start_i = 1;
    override_i = 1;
    repeat (33000) @(negedge clk_i);
    receive_input_i = 1;
    t_rx = cyc;
    await(2, 1, 10);
    d = t_echo - t_trg;
    check(t_trg >= 2 + 20, 1);
    check(t_echo - t_rx <= 2, 1);
    check(pulses, 16);
    check(transducer_drive_o, 0);
    check(gain_o, 3'h7);
    check(d < BLANK, 1);
    await(1, 1, 50);
    check(echo_cycles_o, d);
    await(4, 0, 50);
    @(negedge clk_i);
    check(lnk.echo, 0);
    check(gain_o, 0);
    start_i = 0;
    override_i = 0;
    receive_input_i = 0;
    $display("single_override done");
  endtask
  // Two returns, internal blanking, clear pulse re-arms
  task automatic multi_blank();
    multi_echo_i = 1;
    await(0, 1, 100);
    start_i = 1;
    repeat (33000) @(negedge clk_i);
    receive_input_i = 1;
    await(2, 1, 2000);
    check(t_echo - t_trg >= BLANK, 1);
    await(3, 1, 100);
    await(3, 0, 100);
    check(clr_len >= 10, 1);
    check(lnk.echo, 0);
    await(2, 1, 10);
    check(t_echo - t_clr - clr_len, 2);
    start_i = 0;
    await(4, 0, 20);
    @(negedge clk_i);
    check(lnk.echo, 0);
    receive_input_i = 0;
    multi_echo_i = 0;
    $display("multi_blank done");
  endtask
  initial begin
    repeat (2) @(negedge clk_i);
    rst_i = 0;
    single_override();
    multi_blank();
    summarize();
  end
endmodule
